/* core/cifp_fifo.sv */
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Flop-based word FIFO with occupancy and error pulses
// --------------------------------------------------------------------
module cifp_fifo
  import cifp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic wr_i,
  input wire cifp_pkg::cifp_word_t wr_word_i,
  // Read side
  input wire logic rd_i,
  output cifp_pkg::cifp_word_t head_o,
  // Status
  output logic [CNT_W-1:0] count_o,
  output logic ovf_o,
  output logic unf_o
);

  cifp_word_t mem [FIFO_DEPTH];
  logic [CNT_W-2:0] wr_ptr;
  logic [CNT_W-2:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  // A write into a full FIFO is dropped, a pop of an empty one ignored
  assign do_wr = wr_i && (count_o != CNT_W'(FIFO_DEPTH));
  assign do_rd = rd_i && (count_o != '0);
  assign head_o = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_word_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_o <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count_o <= count_o + CNT_W'(do_wr) - CNT_W'(do_rd);
    end
  end

  // Error pulses, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_o <= 1'b0;
      unf_o <= 1'b0;
    end else begin
      ovf_o <= wr_i && !do_wr;
      unf_o <= rd_i && !do_rd;
    end
  end

endmodule

/* core/cifp_pkg.sv */
package cifp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int LINK_MHZ = 100;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 256;   // 1,024 bytes of 32-bit words
  localparam int CNT_W = 9;
  localparam int RDY_DATA_BIT = 31;
  localparam int RDY_CTL_BIT = 30;
  localparam int TYPE_MSB = 29;
  localparam int TYPE_LSB = 26;
  localparam logic [3:0] TYPE_IDLE = 4'h0;
  localparam logic [3:0] TYPE_FLOW = 4'h5;
  localparam logic [3:0] TYPE_CMD = 4'h6;
  localparam int CH_DATA = 0;
  localparam int CH_CTL = 1;

  // Stored word: 32 data bits, start and end flags, two spare bits
  typedef struct packed {
    logic [1:0] spare;
    logic sof;
    logic eof;
    logic [31:0] data;
  } cifp_word_t;

  typedef enum logic [1:0] {
    KIND_IDLE = 2'b00,
    KIND_DATA = 2'b01,
    KIND_CTL = 2'b10
  } cifp_kind_t;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [17:0] ADR_CTRL = 18'h00000;
  localparam logic [17:0] ADR_DATA_LO = 18'h00004;
  localparam logic [17:0] ADR_DATA_HI = 18'h00008;
  localparam logic [17:0] ADR_CTL_LO = 18'h0000C;
  localparam logic [17:0] ADR_CTL_HI = 18'h00010;
  localparam logic [17:0] ADR_ERR = 18'h00014;
  localparam logic [17:0] ADR_STATUS = 18'h00018;

  localparam int CTRL_HPAR_EN = 0;
  localparam int CTRL_VPAR_EN = 1;
  localparam int ERR_DATA_OVF = 0;
  localparam int ERR_DATA_UNF = 1;
  localparam int ERR_CTL_OVF = 2;
  localparam int ERR_CTL_UNF = 3;
  localparam int ERR_HPAR = 4;
  localparam int ERR_VPAR = 5;

  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_LO_WM = 8'h00;
  localparam logic [7:0] RST_HI_WM = 8'hC0;

endpackage

/* core/cifp_sync.sv */
`timescale 1ns/1ps

// --------------------------------------------------------------------
// Two-flop synchroniser for levels
// --------------------------------------------------------------------
module cifp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // First flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

/* core/cifp_top.sv */
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ps

module cifp_top
  import cifp_pkg::*;
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Inbound link pins
  input wire logic link_clk_i,
  input wire logic [31:0] link_data_i,
  input wire logic link_parity_i,
  input wire logic link_sof_i,
  // Data frame read bus
  input wire logic data_reader_clock_i,
  input wire logic data_pop_enable_i,
  output cifp_pkg::cifp_word_t data_fifo_word_o,
  output logic data_fifo_drained_o,
  output logic data_frame_avail_low_o,
  // Control frame read bus
  input wire logic ctl_reader_clock_i,
  input wire logic ctl_pop_enable_i,
  output cifp_pkg::cifp_word_t ctl_fifo_word_o,
  output logic ctl_fifo_drained_o,
  output logic ctl_frame_avail_low_o,
  // Flow control with the outbound path
  input wire logic ob_data_nearly_full_i,
  input wire logic ob_ctl_nearly_full_i,
  output logic rx_nearly_full_o,
  output logic local_data_ready_o,
  output logic local_ctl_ready_o
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [34:0] link_sync;
  logic link_clk_q;
  logic link_rise;
  logic [31:0] s1_word;
  logic s1_sof;
  logic s1_par;
  logic s1_stb;
  logic [31:0] s2_word;
  logic s2_sof;
  logic s2_par;
  logic s2_stb;
  cifp_kind_t cur_kind;
  cifp_kind_t next_kind;
  cifp_word_t held;
  cifp_kind_t held_kind;
  logic held_valid;
  logic [1:0] fifo_wr;
  cifp_word_t wr_word;
  logic rdy_data;
  logic rdy_ctl;
  logic [31:0] vacc;
  logic in_frame;
  logic hpar_err;
  logic vpar_err;
  logic [7:0] ctrl;
  logic [7:0] lo_wm [2];
  logic [7:0] hi_wm [2];
  logic [7:0] err;
  logic [7:0] err_set;
  logic [7:0] status;
  logic [CNT_W-1:0] count [2];
  logic [1:0] ovf;
  logic [1:0] unf;
  logic [1:0] above_hi;
  cifp_word_t word_q [2];
  logic [1:0] empty;
  logic [1:0] avail_low;
  logic [1:0] rdr_clk_raw;
  logic [1:0] rdr_en_raw;
  logic wb_req;
  logic wb_hit;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------------
  // Link sampling
  // ------------------------------------------------------------------

  // Link clock and data share one synchroniser so they stay aligned
  cifp_sync #(
    .W(35)
  ) u_link_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({link_clk_i, link_sof_i, link_parity_i, link_data_i}),
    .sync_o(link_sync)
  );

  // Edge detect reads only the synchronised clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_clk_q <= 1'b0;
    end else begin
      link_clk_q <= link_sync[34];
    end
  end
  assign link_rise = link_sync[34] && !link_clk_q;

  // First pipeline stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_word <= 32'h00000000;
      s1_sof <= 1'b0;
      s1_par <= 1'b0;
      s1_stb <= 1'b0;
    end else begin
      s1_stb <= link_rise;
      if (link_rise) begin
        s1_word <= link_sync[31:0];
        s1_par <= link_sync[32];
        s1_sof <= link_sync[33];
      end
    end
  end

  // Second pipeline stage, advanced once per link clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s2_word <= 32'h00000000;
      s2_sof <= 1'b0;
      s2_par <= 1'b0;
      s2_stb <= 1'b0;
    end else begin
      s2_stb <= s1_stb;
      if (s1_stb) begin
        s2_word <= s1_word;
        s2_par <= s1_par;
        s2_sof <= s1_sof;
      end
    end
  end

  // ------------------------------------------------------------------
  // Frame classification and write control
  // ------------------------------------------------------------------

  // Header type picks the destination queue
  always_comb begin
    next_kind = cur_kind;
    if (s2_sof) begin
      case (s2_word[TYPE_MSB:TYPE_LSB])
        TYPE_IDLE: next_kind = KIND_IDLE;
        TYPE_FLOW: next_kind = KIND_CTL;
        TYPE_CMD: next_kind = KIND_CTL;
        default: next_kind = KIND_DATA;
      endcase
    end
  end

  // One word is held back so the EOF flag can be set on it once the
  // next start of frame shows it was the last; costs one link clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_kind <= KIND_IDLE;
      held <= '0;
      held_kind <= KIND_IDLE;
      held_valid <= 1'b0;
    end else if (s2_stb) begin
      cur_kind <= next_kind;
      held.data <= s2_word;
      held.sof <= s2_sof;
      held.eof <= 1'b0;
      held.spare <= 2'b00;
      held_kind <= next_kind;
      held_valid <= (next_kind != KIND_IDLE);
    end
  end

  // Write strobes into the two queues
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_wr <= 2'b00;
      wr_word <= '0;
    end else begin
      fifo_wr <= 2'b00;
      if (s2_stb && held_valid) begin
        fifo_wr[CH_DATA] <= (held_kind == KIND_DATA);
        fifo_wr[CH_CTL] <= (held_kind == KIND_CTL);
        wr_word <= held;
        wr_word.eof <= s2_sof;
      end
    end
  end

  // ------------------------------------------------------------------
  // Parity checks
  // ------------------------------------------------------------------

  // Odd parity per word; frame XOR including its check word is zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vacc <= 32'h00000000;
      in_frame <= 1'b0;
      hpar_err <= 1'b0;
      vpar_err <= 1'b0;
    end else begin
      hpar_err <= 1'b0;
      vpar_err <= 1'b0;
      if (s2_stb) begin
        hpar_err <= ctrl[CTRL_HPAR_EN] && !(^{s2_word, s2_par});
        if (s2_sof) begin
          vpar_err <= ctrl[CTRL_VPAR_EN] && in_frame
                      && (vacc != 32'h00000000);
          vacc <= s2_word;
          in_frame <= 1'b1;
        end else begin
          vacc <= vacc ^ s2_word;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Ready bits and flow control
  // ------------------------------------------------------------------

  // Ready bits captured from headers at the first stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_data <= 1'b0;
      rdy_ctl <= 1'b0;
    end else if (s1_stb && s1_sof) begin
      rdy_data <= s1_word[RDY_DATA_BIT];
      rdy_ctl <= s1_word[RDY_CTL_BIT];
    end
  end

  // Outbound congestion masks the local readies
  assign local_data_ready_o = rdy_data && !ob_data_nearly_full_i;
  assign local_ctl_ready_o = rdy_ctl && !ob_ctl_nearly_full_i;

  // Outbound path clears its ready bits on this
  assign rx_nearly_full_o = |above_hi;

  // ------------------------------------------------------------------
  // Queues and read buses
  // ------------------------------------------------------------------
  assign rdr_clk_raw = {ctl_reader_clock_i, data_reader_clock_i};
  assign rdr_en_raw = {ctl_pop_enable_i, data_pop_enable_i};

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [1:0] rdr_sync;
    logic rdr_clk_q;
    logic rdr_rise;
    logic pop;
    cifp_word_t head;

    // Reader clock and enable cross together
    cifp_sync #(
      .W(2)
    ) u_rdr_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({rdr_clk_raw[ch], rdr_en_raw[ch]}),
      .sync_o(rdr_sync)
    );

    // Reader clock edge
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rdr_clk_q <= 1'b0;
      end else begin
        rdr_clk_q <= rdr_sync[1];
      end
    end
    assign rdr_rise = rdr_sync[1] && !rdr_clk_q;
    assign pop = rdr_rise && rdr_sync[0];

    cifp_fifo u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(fifo_wr[ch]),
      .wr_word_i(wr_word),
      .rd_i(pop),
      .head_o(head),
      .count_o(count[ch]),
      .ovf_o(ovf[ch]),
      .unf_o(unf[ch])
    );

    // Output word moves only on a reader edge with enable high
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        word_q[ch] <= '0;
      end else if (pop && (count[ch] != '0)) begin
        word_q[ch] <= head;
      end
    end

    // Occupancy flags: empty, and the two against the watermarks
    assign empty[ch] = (count[ch] == '0);
    assign avail_low[ch] = !(count[ch] > {1'b0, lo_wm[ch]});
    assign above_hi[ch] = count[ch] > {1'b0, hi_wm[ch]};
  end

  assign data_fifo_word_o = word_q[CH_DATA];
  assign ctl_fifo_word_o = word_q[CH_CTL];
  assign data_fifo_drained_o = empty[CH_DATA];
  assign ctl_fifo_drained_o = empty[CH_CTL];
  assign data_frame_avail_low_o = avail_low[CH_DATA];
  assign ctl_frame_avail_low_o = avail_low[CH_CTL];

  // ------------------------------------------------------------------
  // Error capture
  // ------------------------------------------------------------------

  // All sources already run on clk_i; the link and reader sides were
  // brought over by synchronisers before the events were formed
  always_comb begin
    err_set = 8'h00;
    err_set[ERR_DATA_OVF] = ovf[CH_DATA];
    err_set[ERR_DATA_UNF] = unf[CH_DATA];
    err_set[ERR_CTL_OVF] = ovf[CH_CTL];
    err_set[ERR_CTL_UNF] = unf[CH_CTL];
    err_set[ERR_HPAR] = hpar_err;
    err_set[ERR_VPAR] = vpar_err;
  end

  // ------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign status = {1'b0, local_ctl_ready_o, local_data_ready_o,
                   rx_nearly_full_o, empty[CH_CTL], empty[CH_DATA],
                   rdy_ctl, rdy_data};

  // Address decode and byte select
  always_comb begin
    wb_hit = 1'b1;
    rd_byte = 8'h00;
    case (wb_adr_i)
      ADR_CTRL: rd_byte = ctrl;
      ADR_DATA_LO: rd_byte = lo_wm[CH_DATA];
      ADR_DATA_HI: rd_byte = hi_wm[CH_DATA];
      ADR_CTL_LO: rd_byte = lo_wm[CH_CTL];
      ADR_CTL_HI: rd_byte = hi_wm[CH_CTL];
      ADR_ERR: rd_byte = err;
      ADR_STATUS: rd_byte = status;
      default: wb_hit = 1'b0;
    endcase
  end

  // Single-wait acknowledge; unmapped addresses still end the cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_req && !wb_we_i && wb_hit) begin
        wb_dat_o <= {4{rd_byte}};
      end
    end
  end

  // Control and watermark registers, low byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= RST_CTRL;
      lo_wm[CH_DATA] <= RST_LO_WM;
      lo_wm[CH_CTL] <= RST_LO_WM;
      hi_wm[CH_DATA] <= RST_HI_WM;
      hi_wm[CH_CTL] <= RST_HI_WM;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        ADR_CTRL: ctrl <= wb_dat_i[7:0];
        ADR_DATA_LO: lo_wm[CH_DATA] <= wb_dat_i[7:0];
        ADR_DATA_HI: hi_wm[CH_DATA] <= wb_dat_i[7:0];
        ADR_CTL_LO: lo_wm[CH_CTL] <= wb_dat_i[7:0];
        ADR_CTL_HI: hi_wm[CH_CTL] <= wb_dat_i[7:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Sticky errors, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err <= 8'h00;
    end else if (wb_req && wb_we_i && wb_sel_i[0]
                 && (wb_adr_i == ADR_ERR)) begin
      err <= (err & ~wb_dat_i[7:0]) | err_set;
    end else begin
      err <= err | err_set;
    end
  end

endmodule

/* testbench/cifp_chk.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checker for the inbound frame path
// ------------------------------------------------------------
module cifp_chk
  import cifp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Read buses
  input wire cifp_pkg::cifp_word_t data_fifo_word_o,
  input wire logic data_fifo_drained_o,
  input wire logic data_frame_avail_low_o,
  input wire logic ctl_fifo_drained_o,
  input wire logic ctl_frame_avail_low_o,
  // Flow control
  input wire logic ob_data_nearly_full_i,
  input wire logic ob_ctl_nearly_full_i,
  input wire logic rx_nearly_full_o,
  input wire logic local_data_ready_o,
  input wire logic local_ctl_ready_o
);
  import cifp_pkg::*;

  // Single clock domain, so one default clocking serves all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_next_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held past one cycle");
  rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data driven outside a read answer");
  rdata_write_a: assert property (
    wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("read data driven during a write");
  rdata_lanes_a: assert property (
    wb_ack_o |-> wb_dat_o == {4{wb_dat_o[7:0]}})
    else $error("byte not copied onto all lanes");
  data_empty_a: assert property (
    data_fifo_drained_o |-> data_frame_avail_low_o)
    else $error("data frame flagged while data FIFO empty");
  ctl_empty_a: assert property (
    ctl_fifo_drained_o |-> ctl_frame_avail_low_o)
    else $error("control frame flagged while control FIFO empty");
  near_full_a: assert property (
    rx_nearly_full_o |-> !(data_fifo_drained_o && ctl_fifo_drained_o))
    else $error("nearly full with both FIFOs empty");
  ob_ready_a: assert property (
    (ob_data_nearly_full_i |-> !local_data_ready_o)
    and (ob_ctl_nearly_full_i |-> !local_ctl_ready_o))
    else $error("local ready kept while outbound nearly full");
  word_hold_a: assert property (
    !$stable(data_fifo_word_o) |-> !$past(data_fifo_drained_o))
    else $error("data word changed with nothing stored");
endmodule

/* testbench/cifp_link_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Remote link transmitter, one word per link clock
// ------------------------------------------------------------
module cifp_link_model (
  // Link pins toward the receive path
  output logic link_clk_o,
  output logic [31:0] link_data_o,
  output logic link_parity_o,
  output logic link_sof_o
);
  // Quiet lines at start
  initial begin
    link_clk_o = 1'b0;
    link_data_o = 32'h0;
    link_parity_o = 1'b0;
    link_sof_o = 1'b0;
  end

  // 125 ns link period; clock stands still between words
  task automatic send_word(input logic [31:0] d, input logic s,
                           input logic bad);
    link_data_o = d;
    link_sof_o = s;
    link_parity_o = ~^d ^ bad;
    #31.25;
    link_clk_o = 1'b1;
    #62.5;
    link_clk_o = 1'b0;
    // Hold time over: show the inverse, never a stale value; the next
    // word follows a quarter period later, never in the same step
    link_data_o = ~link_data_o;
    link_parity_o = ~link_parity_o;
    link_sof_o = ~link_sof_o;
    #31.25;
  endtask
endmodule

/* testbench/cifp_top_tb.sv */
`timescale 1ns/1ps

module cifp_top_tb;
  import cifp_pkg::*;

  // ------------------------------------------------------------
  // Signals and design
  // ------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [17:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, link_data;
  logic link_clk, link_par, link_sof, nf, ldr, lcr;
  logic [1:0] rclk, pop, drained, avail_low, ob_nf;
  cifp_word_t word [2];
  cifp_word_t data_q [$];
  cifp_word_t ctl_q [$];
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  cifp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .link_clk_i(link_clk), .link_data_i(link_data),
    .link_parity_i(link_par), .link_sof_i(link_sof),
    .data_reader_clock_i(rclk[0]), .data_pop_enable_i(pop[0]),
    .data_fifo_word_o(word[0]), .data_fifo_drained_o(drained[0]),
    .data_frame_avail_low_o(avail_low[0]), .ctl_reader_clock_i(rclk[1]),
    .ctl_pop_enable_i(pop[1]), .ctl_fifo_word_o(word[1]),
    .ctl_fifo_drained_o(drained[1]), .ctl_frame_avail_low_o(avail_low[1]),
    .ob_data_nearly_full_i(ob_nf[0]), .ob_ctl_nearly_full_i(ob_nf[1]),
    .rx_nearly_full_o(nf), .local_data_ready_o(ldr),
    .local_ctl_ready_o(lcr));
  cifp_link_model u_link (.link_clk_o(link_clk), .link_data_o(link_data),
    .link_parity_o(link_par), .link_sof_o(link_sof));

  // 100 MHz system clock
  always #5 clk_i = ~clk_i;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("ERROR at %0t: run timed out", $time);
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Flags as {drained, avail_low, nearly_full, local readies}
  task automatic flags(input logic [6:0] e);
    chk(36'({drained, avail_low, nf, ldr, lcr}), 36'(e));
  endtask

  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [17:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk(36'(wb_ack_o), 36'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(36'(q), 36'(e));
  endtask

  // Header, payload, then check word closing vertical parity
  task automatic frame(input logic [3:0] ty, input logic [1:0] rdy,
                       input int n, input logic bh, input logic bv);
    logic [31:0] w, x;
    cifp_word_t e;
    x = 32'h0;
    for (int i = 0; i <= n + 1; i++) begin
      w = (i == 0) ? {rdy, ty, 26'h0ABCDE} :
          (i <= n) ? 32'h5A000000 + i : x ^ {31'h0, bv};
      x ^= w;
      u_link.send_word(w, i == 0, bh && i == 1);
      e = '{spare: 2'b00, sof: i == 0, eof: i == n + 1, data: w};
      if (ty == TYPE_FLOW || ty == TYPE_CMD) ctl_q.push_back(e);
      else if (ty != TYPE_IDLE) data_q.push_back(e);
    end
  endtask

  // One reader clock with enable; reader edges seen late, so wait
  task automatic rpop(input int c, input logic en, output cifp_word_t w);
    pop[c] <= en;
    @(posedge clk_i);
    rclk[c] <= 1'b1;
    repeat (3) @(posedge clk_i);
    rclk[c] <= 1'b0;
    pop[c] <= 1'b0;
    repeat (6) @(posedge clk_i);
    w = word[c];
  endtask

  task automatic drain(input int c);
    cifp_word_t w, e;
    int n;
    n = c ? ctl_q.size() : data_q.size();
    for (int i = 0; i < n; i++) begin
      e = c ? ctl_q.pop_front() : data_q.pop_front();
      chk(36'(drained[c]), 36'h0);
      rpop(c, 1'b1, w);
      chk(w, e);
    end
    chk(36'(drained[c]), 36'h1);
    rpop(c, 1'b0, w);
    chk(w, e);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    flags(7'b1111000);
    chk(word[0], 36'h0);
    rd(ADR_DATA_HI, {4{RST_HI_WM}});
    rd(ADR_CTRL, {4{RST_CTRL}});
    rd(18'h00100, 32'h0);
  endtask

  // Watermarks at the count boundary, ready tracking, sorting
  task automatic t_frames;
    cifp_word_t w;
    wr(ADR_CTRL, 8'h03);
    wr(ADR_DATA_LO, 8'h03);
    wr(ADR_DATA_HI, 8'h03);
    frame(4'h1, 2'b11, 2, 1'b0, 1'b0);
    frame(TYPE_CMD, 2'b10, 1, 1'b0, 1'b0);
    frame(TYPE_IDLE, 2'b10, 0, 1'b0, 1'b0);
    frame(TYPE_IDLE, 2'b01, 0, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    flags(7'b0000101);
    ob_nf <= 2'b10;
    @(posedge clk_i);
    flags(7'b0000100);
    ob_nf <= 2'b00;
    rpop(0, 1'b1, w);
    chk(w, data_q.pop_front());
    flags(7'b0001001);
    drain(0);
    drain(1);
    flags(7'b1111001);
    rd(ADR_ERR, 32'h0);
  endtask

  // Underflow, then parity faults with checkers on and off
  task automatic t_errors;
    cifp_word_t w;
    rpop(0, 1'b1, w);
    repeat (5) @(posedge clk_i);
    rd(ADR_ERR, {4{8'h02}});
    wr(ADR_ERR, 8'h3F);
    rd(ADR_ERR, 32'h0);
    frame(4'h2, 2'b11, 1, 1'b1, 1'b1);
    frame(TYPE_IDLE, 2'b11, 0, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    rd(ADR_ERR, {4{8'h30}});
    wr(ADR_ERR, 8'h3F);
    wr(ADR_CTRL, 8'h00);
    frame(4'h2, 2'b11, 1, 1'b1, 1'b1);
    frame(TYPE_IDLE, 2'b11, 0, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    rd(ADR_ERR, 32'h0);
    flags(7'b1010111);
    ob_nf <= 2'b01;
    @(posedge clk_i);
    flags(7'b1010101);
    rd(ADR_STATUS, {4{8'h5B}});
    ob_nf <= 2'b00;
    data_q.delete();
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 18'h0;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    rclk = 2'b00;
    pop = 2'b00;
    ob_nf = 2'b00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_frames();
    t_errors();
    finish_test();
  end
endmodule

bind cifp_top cifp_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .data_fifo_word_o(data_fifo_word_o),
  .data_fifo_drained_o(data_fifo_drained_o),
  .data_frame_avail_low_o(data_frame_avail_low_o),
  .ctl_fifo_drained_o(ctl_fifo_drained_o),
  .ctl_frame_avail_low_o(ctl_frame_avail_low_o),
  .ob_data_nearly_full_i(ob_data_nearly_full_i),
  .ob_ctl_nearly_full_i(ob_ctl_nearly_full_i),
  .rx_nearly_full_o(rx_nearly_full_o),
  .local_data_ready_o(local_data_ready_o),
  .local_ctl_ready_o(local_ctl_ready_o));
